// ==== rtl/rbm_pkg.sv ====
// constants, register map and mapping helpers for the rom bank mapper
// ****************************************************************
// ****************************************************************
package rbm_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int EXT_ACCESS_NS = 120;
  // least time rounds up to whole cycles
  localparam int ACC_CYC = (EXT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] EXT_WAIT = 4'(ACC_CYC + SYNC_STAGES);
  localparam logic [3:0] INT_WAIT = 4'h1;

  // ****************************************************************
  // register map (index; byte address is four times the index)
  // ****************************************************************
  localparam int APB_AW = 12;
  localparam logic [9:0] IDX_PROG_BANK = 10'h031;
  localparam logic [9:0] IDX_DATA_BANK = 10'h032;
  localparam logic [9:0] IDX_MAP_STATUS = 10'h033;
  localparam logic [7:0] BANK_RESET = 8'h00;

  // ****************************************************************
  // address layout
  // ****************************************************************
  localparam int BANK_W = 8;
  localparam int PHYS_W = 23;
  localparam int EXT_AW = 22;
  localparam int ROM_AW = 21;
  localparam logic [1:0] PROG_WIN_TAG = 2'h1;
  localparam logic [1:0] REGION_ROM = 2'h0;
  localparam logic INT_ENABLED = 1'b1;
  localparam logic ARR_SINGLE = 1'b1;
  localparam logic [EXT_AW-1:0] EXT_ADDR_IDLE = 22'h3fffff;

  // true when the cpu address lies in a banked window
  function automatic logic in_window(input logic [15:0] a);
    return a[15] || (a[15:14] == PROG_WIN_TAG);
  endfunction : in_window

  // expand a cpu address through the bank registers
  function automatic logic [PHYS_W-1:0] phys_of(input logic [15:0] a,
                                                input logic [7:0] pb,
                                                input logic [7:0] db);
    if (a[15]) begin
      return {db, a[14:0]};
    end
    return {1'b0, pb, a[13:0]};
  endfunction : phys_of

endpackage : rbm_pkg

// ==== rtl/rbm_mapper.sv ====
// rom bank registers and internal/external memory routing
`timescale 1ns/1ns
module rbm_mapper
  import rbm_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu access port
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_done,
  output logic cpu_busy,
  // internal rom
  output logic rom_en,
  output logic [ROM_AW-1:0] rom_addr,
  input wire logic [7:0] rom_rdata,
  // configuration pins
  input wire logic internal_memory_select,
  input wire logic chip_select_arrangement,
  // external memory pins
  output logic [EXT_AW-1:0] ext_addr,
  output logic ext_a22_lower_half_chip_select,
  output logic ext_chip_select_upper_half,
  output logic ext_rw,
  input wire logic [7:0] ext_data_in,
  output logic [7:0] ext_data_out,
  output logic ext_data_oe
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DRIVE = 2'b01
  } rbm_state_e;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [9:0] sync1_ff, sync2_ff;
  logic int_sel_s, arr_s;
  logic [7:0] ext_data_s;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 10'h000;
      sync2_ff <= 10'h000;
    end else begin
      sync1_ff <= {internal_memory_select, chip_select_arrangement,
                   ext_data_in};
      sync2_ff <= sync1_ff;
    end
  end
  assign int_sel_s = sync2_ff[9];
  assign arr_s = sync2_ff[8];
  assign ext_data_s = sync2_ff[7:0];

  // ****************************************************************
  // apb register file
  // ****************************************************************
  logic [7:0] prog_bank_ff, nxt_prog_bank, data_bank_ff, nxt_data_bank;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic [9:0] reg_idx;
  logic apb_acc, apb_done;
  logic [31:0] status_word;

  assign reg_idx = paddr[APB_AW-1:2];
  assign apb_acc = psel && penable;
  // one wait state keeps prdata and pready straight from flops
  assign apb_done = apb_acc && pready_ff;

  // next values for the bus slave and bank registers
  always_comb begin
    nxt_prog_bank = prog_bank_ff;
    nxt_data_bank = data_bank_ff;
    nxt_pready = apb_acc && !pready_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    if (apb_acc && !pready_ff) begin
      nxt_prdata = 32'h0000_0000;
      case (reg_idx)
        IDX_PROG_BANK: nxt_prdata = {24'h000000, prog_bank_ff};
        IDX_DATA_BANK: nxt_prdata = {24'h000000, data_bank_ff};
        IDX_MAP_STATUS: nxt_prdata = status_word;
        default: nxt_pslverr = 1'b1; // unmapped address
      endcase
    end
    if (apb_done && pwrite) begin
      // bank numbers used verbatim
      if (reg_idx == IDX_PROG_BANK) begin
        nxt_prog_bank = pwdata[7:0];
      end
      if (reg_idx == IDX_DATA_BANK) begin
        nxt_data_bank = pwdata[7:0];
      end
    end
  end

  // reset gives a known bank even though software must set it anyway
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_bank_ff <= BANK_RESET;
      data_bank_ff <= BANK_RESET;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prog_bank_ff <= nxt_prog_bank;
      data_bank_ff <= nxt_data_bank;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ****************************************************************
  // access sequencer
  // ****************************************************************
  rbm_state_e state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [PHYS_W-1:0] phys_ff, nxt_phys, req_phys;
  logic we_ff, nxt_we, route_int_ff, nxt_route_int, arr_ff, nxt_arr;
  logic [7:0] rdata_ff, nxt_rdata, dout_ff, nxt_dout;
  logic done_ff, nxt_done, rom_en_ff, nxt_rom_en, doe_ff, nxt_doe;
  logic [ROM_AW-1:0] rom_addr_ff, nxt_rom_addr;
  logic [EXT_AW-1:0] ea_ff, nxt_ea;
  logic pin_a22_ff, nxt_pin_a22, pin_cs_ff, nxt_pin_cs, rw_ff, nxt_rw;
  logic accept, req_int, busy_ff, nxt_busy;

  // a request outside the banked windows is not ours and is ignored
  assign accept = (state_ff == ST_IDLE) && cpu_req && in_window(cpu_addr);
  assign req_phys = phys_of(cpu_addr, prog_bank_ff, data_bank_ff);
  // only the lowest 2M region can be served by the rom
  assign req_int = (int_sel_s == INT_ENABLED) &&
                   (req_phys[PHYS_W-1:ROM_AW] == REGION_ROM);

  // next values for the sequencer and the external bus
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_phys = phys_ff;
    nxt_we = we_ff;
    nxt_route_int = route_int_ff;
    nxt_arr = arr_ff;
    nxt_rdata = rdata_ff;
    nxt_dout = dout_ff;
    nxt_done = 1'b0;
    nxt_rom_en = 1'b0;
    nxt_rom_addr = rom_addr_ff;
    nxt_doe = doe_ff;
    nxt_ea = ea_ff;
    nxt_pin_a22 = pin_a22_ff;
    nxt_pin_cs = pin_cs_ff;
    nxt_rw = rw_ff;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_state = ST_DRIVE;
          nxt_phys = req_phys;
          nxt_we = cpu_we;
          nxt_arr = arr_s;
          nxt_route_int = req_int;
          if (req_int) begin
            // rom read; a write to rom simply completes
            nxt_cnt = INT_WAIT;
            nxt_rom_en = !cpu_we;
            nxt_rom_addr = req_phys[ROM_AW-1:0];
          end else begin
            nxt_cnt = EXT_WAIT;
            nxt_ea = req_phys[EXT_AW-1:0];
            nxt_rw = !cpu_we;
            nxt_doe = cpu_we;
            nxt_dout = cpu_wdata;
            if (arr_s == ARR_SINGLE) begin
              nxt_pin_cs = 1'b0;
              nxt_pin_a22 = req_phys[PHYS_W-1];
            end else begin
              nxt_pin_a22 = req_phys[PHYS_W-1];
              nxt_pin_cs = !req_phys[PHYS_W-1];
            end
          end
        end
      end
      ST_DRIVE: begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h1) begin
          // data read through the synchroniser, hence the extra wait
          nxt_rdata = route_int_ff ? rom_rdata : ext_data_s;
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
          nxt_ea = EXT_ADDR_IDLE;
          nxt_pin_a22 = 1'b1;
          nxt_pin_cs = 1'b1;
          nxt_rw = 1'b1;
          nxt_doe = 1'b0;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    nxt_busy = (nxt_state == ST_DRIVE);
  end

  // bus idles high so external chips stay deselected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      phys_ff <= 23'h000000;
      we_ff <= 1'b0;
      route_int_ff <= 1'b0;
      arr_ff <= 1'b0;
      rdata_ff <= 8'h00;
      dout_ff <= 8'h00;
      done_ff <= 1'b0;
      rom_en_ff <= 1'b0;
      rom_addr_ff <= 21'h000000;
      doe_ff <= 1'b0;
      ea_ff <= EXT_ADDR_IDLE;
      pin_a22_ff <= 1'b1;
      pin_cs_ff <= 1'b1;
      rw_ff <= 1'b1;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      phys_ff <= nxt_phys;
      we_ff <= nxt_we;
      route_int_ff <= nxt_route_int;
      arr_ff <= nxt_arr;
      rdata_ff <= nxt_rdata;
      dout_ff <= nxt_dout;
      done_ff <= nxt_done;
      rom_en_ff <= nxt_rom_en;
      rom_addr_ff <= nxt_rom_addr;
      doe_ff <= nxt_doe;
      ea_ff <= nxt_ea;
      pin_a22_ff <= nxt_pin_a22;
      pin_cs_ff <= nxt_pin_cs;
      rw_ff <= nxt_rw;
      busy_ff <= nxt_busy;
    end
  end

  // status word: busy, route, region, synced strap levels
  assign status_word = {26'h0000000, arr_s, int_sel_s,
                        phys_ff[PHYS_W-1:ROM_AW], route_int_ff,
                        state_ff == ST_DRIVE};

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign cpu_rdata = rdata_ff;
  assign cpu_done = done_ff;
  assign cpu_busy = busy_ff;
  assign rom_en = rom_en_ff;
  assign rom_addr = rom_addr_ff;
  assign ext_addr = ea_ff;
  assign ext_a22_lower_half_chip_select = pin_a22_ff;
  assign ext_chip_select_upper_half = pin_cs_ff;
  assign ext_rw = rw_ff;
  assign ext_data_out = dout_ff;
  assign ext_data_oe = doe_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  localparam int EXT_LAT = ACC_CYC + SYNC_STAGES + 1;
  localparam int INT_LAT = 2;

  sequence s_ext_accept;
    accept && !req_int;
  endsequence
  sequence s_int_accept;
    accept && req_int;
  endsequence

  chk_prog_window: assert property (@(posedge pclk)
    disable iff (!presetn) accept && !cpu_addr[15] |=> phys_ff ==
      {1'b0, $past(prog_bank_ff), $past(cpu_addr[13:0])})
    else $error("program window mapped wrongly");
  chk_data_window: assert property (@(posedge pclk)
    disable iff (!presetn) accept && cpu_addr[15] |=> phys_ff ==
      {$past(data_bank_ff), $past(cpu_addr[14:0])})
    else $error("data window mapped wrongly");
  chk_bank_write: assert property (@(posedge pclk)
    disable iff (!presetn) apb_done && pwrite && reg_idx == IDX_DATA_BANK |=>
      data_bank_ff == $past(pwdata[7:0]))
    else $error("data bank write lost");
  chk_rom_read: assert property (@(posedge pclk)
    disable iff (!presetn) s_int_accept ##0 !cpu_we |=>
      rom_en && rom_addr == phys_ff[ROM_AW-1:0] ##1 !rom_en && cpu_done)
    else $error("rom read not issued or completed");
  chk_rom_disabled: assert property (@(posedge pclk)
    disable iff (!presetn) accept && int_sel_s != INT_ENABLED |=>
      !route_int_ff && !rom_en)
    else $error("rom used while disabled");
  chk_ext_done: assert property (@(posedge pclk)
    disable iff (!presetn) s_ext_accept |-> ##EXT_LAT cpu_done &&
      cpu_rdata == $past(ext_data_s))
    else $error("external access latency wrong");
  chk_int_done: assert property (@(posedge pclk)
    disable iff (!presetn) s_int_accept |-> ##INT_LAT cpu_done)
    else $error("internal access latency wrong");
  chk_single_select: assert property (@(posedge pclk)
    disable iff (!presetn) cpu_busy && !route_int_ff && arr_ff == ARR_SINGLE
      |-> !ext_chip_select_upper_half &&
      ext_a22_lower_half_chip_select == phys_ff[PHYS_W-1])
    else $error("single select decode wrong");
  chk_dual_select: assert property (@(posedge pclk)
    disable iff (!presetn) cpu_busy && !route_int_ff && arr_ff != ARR_SINGLE
      |-> ext_chip_select_upper_half != ext_a22_lower_half_chip_select &&
      ext_a22_lower_half_chip_select == phys_ff[PHYS_W-1])
    else $error("two select decode wrong");
  chk_int_quiet: assert property (@(posedge pclk)
    disable iff (!presetn) cpu_busy && route_int_ff |->
      ext_chip_select_upper_half && ext_a22_lower_half_chip_select &&
      ext_addr == EXT_ADDR_IDLE && !ext_data_oe)
    else $error("external pins active during rom access");

endmodule : rbm_mapper

// ==== verification/rbm_internal_memory_select.sv ====
// behavioural external memory chips on the parallel bus
`timescale 1ns/1ns
module rbm_internal_memory_select (
  // clock
  input wire logic pclk,
  // memory pins
  input wire logic [21:0] ext_addr,
  input wire logic ext_a22_lower_half_chip_select,
  input wire logic ext_chip_select_upper_half,
  input wire logic ext_rw,
  input wire logic [7:0] ext_data_out,
  input wire logic ext_data_oe,
  input wire logic chip_select_arrangement,
  // data back to the block
  output logic [7:0] ext_data_in
);
  logic sel;
  logic [7:0] last_q = 8'h00;
  logic [7:0] wr_byte = 8'h00;
  logic [21:0] wr_addr = 22'h000000;
  // single mode: one select on the upper pin; two-select mode: either pin
  assign sel = !ext_chip_select_upper_half ||
               (!chip_select_arrangement && !ext_a22_lower_half_chip_select);
  // answer reads; a released bus toggles so a stale byte never looks valid
  always_comb begin
    if (sel && ext_rw) begin
      ext_data_in = ext_addr[7:0] ^ ext_addr[15:8] ^ 8'ha5;
    end else begin
      ext_data_in = ~last_q;
    end
  end
  // capture writes while selected and driven
  always_ff @(posedge pclk) begin
    last_q <= ext_data_in;
    if (sel && !ext_rw && ext_data_oe) begin
      wr_byte <= ext_data_out;
      wr_addr <= ext_addr;
    end
  end
endmodule : rbm_internal_memory_select

// ==== verification/rbm_mapper_tb_top.sv ====
// self-checking testbench for the rom bank mapper
`timescale 1ns/1ns
module rbm_mapper_tb_top import rbm_pkg::*;;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, cpu_req = 1'h0, cpu_we = 1'h0;
  logic [APB_AW-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_wdata = 8'h00, cpu_rdata, rom_rdata, ext_data_in;
  logic cpu_done, cpu_busy, rom_en, ext_rw, ext_data_oe, lo_pin, hi_pin;
  logic [ROM_AW-1:0] rom_addr;
  logic internal_memory_select = 1'h1, chip_select_arrangement = 1'h1;
  logic [EXT_AW-1:0] ext_addr;
  logic [7:0] ext_data_out;
  integer n_mismatch = 0, n_compared = 0, cyc = 0;
  // ****************************************************************
  // design, rom and far side
  // ****************************************************************
  rbm_mapper dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_done(cpu_done),
    .cpu_busy(cpu_busy), .rom_en(rom_en), .rom_addr(rom_addr),
    .rom_rdata(rom_rdata), .internal_memory_select(internal_memory_select),
    .chip_select_arrangement(chip_select_arrangement), .ext_addr(ext_addr),
    .ext_a22_lower_half_chip_select(lo_pin),
    .ext_chip_select_upper_half(hi_pin), .ext_rw(ext_rw),
    .ext_data_in(ext_data_in), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe));
  rbm_internal_memory_select mem (.pclk(pclk), .ext_addr(ext_addr),
    .ext_a22_lower_half_chip_select(lo_pin),
    .ext_chip_select_upper_half(hi_pin), .ext_rw(ext_rw),
    .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
    .chip_select_arrangement(chip_select_arrangement),
    .ext_data_in(ext_data_in));
  // rom content is a pattern of its address
  assign rom_rdata = rom_addr[7:0] ^ 8'h3c;
  // clock and hang guard; the whole run takes well under 3000 cycles
  initial forever #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [31:0] e, g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // one apb transfer; holds everything until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    // only the bench timeout ends this wait
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // one cpu access; snap holds the pins one cycle after the request is taken
  task automatic cpu(input logic we, input logic [15:0] a,
                     input logic [7:0] wd, output logic [7:0] rd,
                     output logic [25:0] snap, output logic done);
    int n;
    n = 0;
    @(posedge pclk);
    cpu_req <= 1'h1;
    cpu_we <= we;
    cpu_addr <= a;
    cpu_wdata <= wd;
    @(posedge pclk);
    cpu_req <= 1'h0;
    // sampled at the edge, so these are the levels of the first busy cycle
    @(posedge pclk);
    snap = {ext_addr, lo_pin, hi_pin, ext_rw, ext_data_oe};
    check("busy", {31'h0, a[15] | a[14]}, {31'h0, cpu_busy});
    // a refused request never answers, so this wait is bounded
    while (cpu_done !== 1'h1 && n < 20) begin
      @(posedge pclk);
      n = n + 1;
    end
    done = (cpu_done === 1'h1);
    rd = cpu_rdata;
  endtask : cpu
  // ****************************************************************
  // scenarios
  // ****************************************************************
  // idle levels at the first edge after reset is released
  task automatic t_reset;
    @(posedge pclk);
    check("reset_pins", {6'h0, 22'h3fffff, 4'he},
          {6'h0, ext_addr, lo_pin, hi_pin, ext_rw, ext_data_oe});
    check("reset_ctl", 32'h0, {27'h0, cpu_done, cpu_busy, rom_en, pready,
          pslverr});
    $display("t_reset finished");
  endtask : t_reset
  task automatic t_regs;
    logic [31:0] rd;
    logic err;
    apb(1'h0, 12'h0c4, 32'h0, rd, err);
    check("prog_reset", 32'h0, rd);
    apb(1'h1, 12'h0c4, 32'hffffff5a, rd, err);
    apb(1'h1, 12'h0c8, 32'h000000c3, rd, err);
    apb(1'h1, 12'h000, 32'h00000011, rd, err);
    check("unmapped_wr_err", 32'h1, {31'h0, err});
    apb(1'h0, 12'h0c4, 32'h0, rd, err);
    check("prog_bank", 32'h5a, rd);
    apb(1'h0, 12'h0c8, 32'h0, rd, err);
    check("data_bank", 32'hc3, rd);
    check("mapped_err", 32'h0, {31'h0, err});
    apb(1'h0, 12'h000, 32'h0, rd, err);
    check("unmapped_err", 32'h1, {31'h0, err});
    check("unmapped_rd", 32'h0, rd);
    // status ignores writes; both straps high, nothing accessed yet
    apb(1'h1, 12'h0cc, 32'hffffffff, rd, err);
    check("status_wr_err", 32'h0, {31'h0, err});
    apb(1'h0, 12'h0cc, 32'h0, rd, err);
    check("status", 32'h30, rd);
    $display("t_regs finished");
  endtask : t_regs
  // every strap combination against banked reads in regions 0, 1 and 3
  task automatic t_map;
    logic [15:0] ca[4] = '{16'h4123, 16'h8abc, 16'h7fff, 16'hc001};
    logic [7:0] pbk[4] = '{8'h05, 8'h10, 8'hff, 8'h00};
    logic [7:0] dbk[4] = '{8'h00, 8'h55, 8'h00, 8'hc3};
    logic [31:0] rd;
    logic [7:0] got;
    logic [22:0] p;
    logic [25:0] snap, es;
    logic err, done, inr;
    for (int m = 0; m < 4; m++) begin
      internal_memory_select <= m[1];
      chip_select_arrangement <= m[0];
      repeat (4) @(posedge pclk);
      for (int k = 0; k < 4; k++) begin
        apb(1'h1, 12'h0c4, {24'h0, pbk[k]}, rd, err);
        apb(1'h1, 12'h0c8, {24'h0, dbk[k]}, rd, err);
        cpu(1'h0, ca[k], 8'h00, got, snap, done);
        p = ca[k][15] ? {dbk[k], ca[k][14:0]} : {1'h0, pbk[k], ca[k][13:0]};
        inr = (p[22:21] == 2'h0) && m[1];
        es = {p[21:0], p[22], m[0] ? 1'h0 : ~p[22], 1'h1, 1'h0};
        if (inr) begin
          es = {22'h3fffff, 4'he};
          check("rom_addr", {11'h0, p[20:0]}, {11'h0, rom_addr});
        end
        check("done", 32'h1, {31'h0, done});
        check("pins", {6'h0, es}, {6'h0, snap});
        check("rdata", {24'h0, inr ? p[7:0] ^ 8'h3c :
              p[7:0] ^ p[15:8] ^ 8'ha5}, {24'h0, got});
      end
    end
    $display("t_map finished");
  endtask : t_map
  // external write in two-select mode, then a refused low address
  task automatic t_write_refuse;
    logic [31:0] rd;
    logic [7:0] got;
    logic [25:0] snap;
    logic err, done;
    internal_memory_select <= 1'h0;
    chip_select_arrangement <= 1'h0;
    repeat (4) @(posedge pclk);
    apb(1'h1, 12'h0c8, 32'h000000c3, rd, err);
    cpu(1'h1, 16'hc001, 8'h96, got, snap, done);
    check("wr_pins", {6'h0, 22'h21c001, 4'h9}, {6'h0, snap});
    check("wr_byte", 32'h96, {24'h0, mem.wr_byte});
    check("wr_addr", 32'h21c001, {10'h0, mem.wr_addr});
    check("idle_addr", 32'h3fffff, {10'h0, ext_addr});
    cpu(1'h0, 16'h1000, 8'h00, got, snap, done);
    check("refused", 32'h0, {31'h0, done});
    // a write into the rom region completes without touching the pins
    internal_memory_select <= 1'h1;
    chip_select_arrangement <= 1'h1;
    repeat (4) @(posedge pclk);
    cpu(1'h1, 16'h4123, 8'h55, got, snap, done);
    check("rom_wr_done", 32'h1, {31'h0, done});
    check("rom_wr_pins", {6'h0, 22'h3fffff, 4'he}, {6'h0, snap});
    $display("t_write_refuse finished");
  endtask : t_write_refuse
  // ****************************************************************
  // main sequence and verdict
  // ****************************************************************
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_regs();
    t_map();
    t_write_refuse();
    end_of_test();
  end
endmodule : rbm_mapper_tb_top
